// ### cmp_ctrl_sva.sv
module cmp_ctrl_sva (
   input logic              ref_clk,
   input logic              reset,
   input cmp_pkg::axi_req_t axi_req,
   input cmp_pkg::axi_rsp_t axi_rsp,
   input logic [1:0]        cmp_raw,
   input logic [1:0]        cmp_enable,
   input logic [1:0]        vin_neg_pos_sel,
   input logic [5:0]        pin_in,
   input logic [5:0]        pin_out,
   input logic [5:0]        pin_oe,
   input logic [5:0]        input_buffer_off,
   input logic              irq_request
);
   // ==========================================================
   // shadow of byte 0 of each register, taken when answered
   // ==========================================================
   logic [7:0] sh_reg [8];
   logic [2:0] idx_reg;
   logic [7:0] wd_reg;
   logic       wen_reg;
   logic       bv_reg;
   logic       quiet;
   logic [2:0] mode;

   always_ff @(posedge ref_clk) begin
      bv_reg <= axi_rsp.bvalid;
      if (axi_req.awvalid && axi_rsp.awready) begin
         idx_reg <= axi_req.awaddr[4:2];
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
         wd_reg <= axi_req.wdata[7:0];
         wen_reg <= axi_req.wstrb[0];
      end
      if (reset) begin
         for (int i = 0; i < 8; i++) begin
            sh_reg[i] <= (i == 4) ? 8'h3F : 8'h00;
         end
      end else if (axi_rsp.bvalid && !bv_reg && wen_reg &&
                   axi_rsp.bresp == 2'h0) begin
         sh_reg[idx_reg] <= wd_reg;
      end
   end
   // the shadow lags the block, so skip the cycles around a write
   assign quiet = !axi_rsp.bvalid && !bv_reg;
   assign mode = sh_reg[0][2:0];

   // ==========================================================
   // properties
   // ==========================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   chk_reset_outputs: assert property (
      $fell(reset) |-> cmp_enable == 2'b00 && irq_request == 1'b0 &&
      input_buffer_off == 6'h0F && pin_oe == 6'h00)
      else $error("outputs wrong after reset");
   chk_off_analog: assert property (
      quiet && mode == 3'h0 |-> cmp_enable == 2'b00 &&
      input_buffer_off == 6'h0F)
      else $error("mode 0 not off with analog pins");
   chk_off_digital: assert property (
      quiet && mode == 3'h7 |-> cmp_enable == 2'b00 &&
      input_buffer_off == 6'h00)
      else $error("mode 7 not off with digital pins");
   chk_switch_modes: assert property (
      quiet |-> vin_neg_pos_sel == (mode == 3'h1 ? {1'b0, sh_reg[0][3]} :
      mode == 3'h2 ? {2{sh_reg[0][3]}} : 2'b00))
      else $error("input switch wrong for mode");
   chk_pin_follow: assert property (
      quiet && mode != 3'h6 |-> pin_out == sh_reg[3][5:0])
      else $error("pin drive differs from port latch");
   chk_pin_compare: assert property (
      (quiet && mode == 3'h6 && $stable(cmp_raw)) [*5] |->
      pin_out == {cmp_raw ^ sh_reg[0][5:4], sh_reg[3][3:0]})
      else $error("comparator pins wrong in mode 6");
   chk_oe_dir: assert property (
      quiet |-> pin_oe == ~sh_reg[4][5:0])
      else $error("output enable differs from direction");
   chk_irq_gate: assert property (
      quiet && irq_request |-> sh_reg[2][3] && sh_reg[2][2] &&
      (|sh_reg[2][1:0]))
      else $error("request without all enables");
   chk_read_answer: assert property (
      axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read not answered next cycle");
endmodule : cmp_ctrl_sva

bind dual_comparator_control cmp_ctrl_sva chk_i (
   .ref_clk, .reset, .axi_req, .axi_rsp, .cmp_raw, .cmp_enable,
   .vin_neg_pos_sel, .pin_in, .pin_out, .pin_oe, .input_buffer_off,
   .irq_request);

// ### cmp_far_side.sv
// ============================================================
// comparator cores and pad ring seen from the block
// ============================================================
module cmp_far_side (
   input  logic       ref_clk,
   input  logic [1:0] cmp_enable,
   input  logic [1:0] vin_diff,
   input  logic [5:0] ext_level,
   input  logic [5:0] pin_out,
   input  logic [5:0] pin_oe,
   output logic [1:0] cmp_raw,
   output logic [5:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] idle_reg = 2'b00;

   // a core without power gives no trustworthy result, so let it wander
   always @(posedge ref_clk) begin
      idle_reg <= ~idle_reg;
   end
   // 1 means the positive input is above the negative one
   assign cmp_raw = (cmp_enable & vin_diff) | (~cmp_enable & idle_reg);
   // a pin driven by the block wins over the external source
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : cmp_far_side

// ### cmp_pkg.sv
package cmp_pkg;

   // ==========================================================
   // bus geometry and register offsets
   // ==========================================================
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NPIN   = 6;
   localparam int NCMP   = 2;

   localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
   localparam logic [ADDR_W-1:0] FLAG_OFS   = 8'h04;
   localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] PORT_OFS   = 8'h0C;
   localparam logic [ADDR_W-1:0] DIR_OFS    = 8'h10;

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int MODE_LSB  = 0;
   localparam int MODE_W    = 3;
   localparam int CIS_BIT   = 3;
   localparam int INV_LSB   = 4;
   localparam int OUT_LSB   = 6;
   localparam int FLAG_LSB  = 0;
   localparam int IE_LSB    = 0;
   localparam int PERIPHERAL_INTERRUPT_ENABLE_BIT  = 2;
   localparam int GIE_BIT   = 3;

   // ==========================================================
   // reset values and constants
   // ==========================================================
   localparam logic [MODE_W-1:0] MODE_OFF_ANALOG  = 3'h0;
   localparam logic [MODE_W-1:0] MODE_THREE_MUX   = 3'h1;
   localparam logic [MODE_W-1:0] MODE_FOUR_MUX    = 3'h2;
   localparam logic [MODE_W-1:0] MODE_COMMON_REF  = 3'h3;
   localparam logic [MODE_W-1:0] MODE_INDEPENDENT = 3'h4;
   localparam logic [MODE_W-1:0] MODE_ONE_CMP     = 3'h5;
   localparam logic [MODE_W-1:0] MODE_REF_OUTPUTS = 3'h6;
   localparam logic [MODE_W-1:0] MODE_OFF_DIGITAL = 3'h7;

   localparam int PIN_C1_OUT = 4;
   localparam int PIN_C2_OUT = 5;

   localparam logic [NPIN-1:0] DIR_RESET   = 6'h3F;
   localparam logic [NPIN-1:0] PORT_RESET  = 6'h00;
   localparam logic [1:0]      QPHASE_Q1   = 2'h0;
   localparam logic [1:0]      RESP_OKAY   = 2'h0;
   localparam logic [1:0]      RESP_SLVERR = 2'h2;
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

   // ==========================================================
   // bus carriers
   // ==========================================================
   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } axi_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } axi_rsp_t;

   // pins: 0 c1 neg, 1 c1 pos, 2 c2 neg, 3 c2 pos, 4 c1 out, 5 c2 out
   function automatic logic [NPIN-1:0] analog_mask(
      input logic [MODE_W-1:0] mode);
      case (mode)
         MODE_OFF_ANALOG:  analog_mask = 6'h0F;
         MODE_THREE_MUX:   analog_mask = 6'h0F;
         MODE_FOUR_MUX:    analog_mask = 6'h0F;
         MODE_COMMON_REF:  analog_mask = 6'h0D;
         MODE_INDEPENDENT: analog_mask = 6'h0F;
         MODE_ONE_CMP:     analog_mask = 6'h0C;
         MODE_REF_OUTPUTS: analog_mask = 6'h0D;
         default:          analog_mask = 6'h00;
      endcase
   endfunction : analog_mask

endpackage : cmp_pkg

// ### cmp_sync.sv
module cmp_sync (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic [1:0] async_in,
   output logic      [1:0] sync_out
);

   // ==========================================================
   // two-stage synchroniser for the raw comparator results
   // ==========================================================
   typedef struct packed {
      logic [1:0] stage1;
      logic [1:0] stage2;
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;

   always_comb begin
      st_next        = st_reg;
      st_next.stage1 = async_in;
      st_next.stage2 = st_reg.stage1;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.stage2;

endmodule : cmp_sync

// ### dual_comparator_control.sv
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
module dual_comparator_control (
   input  wire logic                      ref_clk,
   input  wire logic                      reset,
   input  wire cmp_pkg::axi_req_t         axi_req,
   output cmp_pkg::axi_rsp_t              axi_rsp,
   input  wire logic [cmp_pkg::NCMP-1:0]  cmp_raw,
   output logic      [cmp_pkg::NCMP-1:0]  cmp_enable,
   output logic      [cmp_pkg::NCMP-1:0]  vin_neg_pos_sel,
   input  wire logic [cmp_pkg::NPIN-1:0]  pin_in,
   output logic      [cmp_pkg::NPIN-1:0]  pin_out,
   output logic      [cmp_pkg::NPIN-1:0]  pin_oe,
   output logic      [cmp_pkg::NPIN-1:0]  input_buffer_off,
   output logic                           irq_request
);

   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      cmp_pkg::axi_rsp_t                  rsp;
      logic                               aw_held;
      logic [cmp_pkg::ADDR_W-1:0]         awaddr;
      logic                               w_held;
      logic [cmp_pkg::DATA_W-1:0]         wdata;
      logic [3:0]                         wstrb;
      logic [cmp_pkg::MODE_W-1:0]         mode;
      logic                               inverting_input_select;
      logic [cmp_pkg::NCMP-1:0]           inv;
      logic [cmp_pkg::NCMP-1:0]           flag;
      logic [cmp_pkg::NCMP-1:0]           ie;
      logic                               peripheral_interrupt_enable;
      logic                               global_interrupt_enable;
      logic [cmp_pkg::NPIN-1:0]           port_latch;
      logic [cmp_pkg::NPIN-1:0]           dir;
      logic [1:0]                         phase;
      logic [cmp_pkg::NCMP-1:0]           ref_latch;
      logic [cmp_pkg::NCMP-1:0]           sample;
      logic                               irq;
      logic [cmp_pkg::NPIN-1:0]           pin_out;
      logic [cmp_pkg::NPIN-1:0]           pin_oe;
      logic [cmp_pkg::NPIN-1:0]           analog;
      logic [cmp_pkg::NCMP-1:0]           enable;
      logic [cmp_pkg::NCMP-1:0]           sel;
   } ctl_state_t;

   ctl_state_t st_reg;
   ctl_state_t st_next;

   logic [cmp_pkg::NCMP-1:0] raw_sync;
   logic [cmp_pkg::NCMP-1:0] cmp_out;
   logic [cmp_pkg::NCMP-1:0] mismatch;
   logic [cmp_pkg::NPIN-1:0] analog_now;

   // ==========================================================
   // synchroniser
   // ==========================================================
   cmp_sync u_sync (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .async_in (cmp_raw),
      .sync_out (raw_sync)
   );

   // ==========================================================
   // helpers
   // ==========================================================
   function automatic logic hit(
      input logic [cmp_pkg::ADDR_W-1:0] addr,
      input logic [cmp_pkg::ADDR_W-1:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   function automatic logic [cmp_pkg::DATA_W-1:0] ctrl_word(
      input ctl_state_t s,
      input logic [cmp_pkg::NCMP-1:0] outs);
      logic [cmp_pkg::DATA_W-1:0] w;
      w = cmp_pkg::WORD_ZERO;
      w[cmp_pkg::MODE_LSB +: cmp_pkg::MODE_W] = s.mode;
      w[cmp_pkg::CIS_BIT] = s.inverting_input_select;
      w[cmp_pkg::INV_LSB +: cmp_pkg::NCMP] = s.inv;
      w[cmp_pkg::OUT_LSB +: cmp_pkg::NCMP] = outs;
      ctrl_word = w;
   endfunction : ctrl_word

   // ==========================================================
   // comparator view
   // ==========================================================
   always_comb begin
      cmp_out    = raw_sync ^ st_reg.inv;
      mismatch   = st_reg.ref_latch ^ st_reg.sample;
      analog_now = cmp_pkg::analog_mask(st_reg.mode);
   end

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      logic                       do_write;
      logic                       do_read;
      logic [cmp_pkg::DATA_W-1:0] rd;
      logic                       rd_ok;
      logic                       wr_ok;
      logic                       ctrl_touch;
      logic [cmp_pkg::MODE_W-1:0] m;
      do_write   = 1'b0;
      do_read    = 1'b0;
      rd         = cmp_pkg::WORD_ZERO;
      rd_ok      = 1'b0;
      wr_ok      = 1'b0;
      ctrl_touch = 1'b0;
      m          = cmp_pkg::MODE_OFF_ANALOG;
      st_next    = st_reg;

      // instruction cycle phase; second latch on first quarter
      st_next.phase = st_reg.phase + 2'h1;
      if (st_reg.phase == cmp_pkg::QPHASE_Q1) begin
         st_next.sample = cmp_out;
      end

      // a live mismatch keeps the flag up, whatever software did
      st_next.flag = st_reg.flag | mismatch;

      // ---- write channel capture, either order ----
      if (axi_req.awvalid && st_reg.rsp.awready) begin
         st_next.aw_held = 1'b1;
         st_next.awaddr  = axi_req.awaddr;
      end
      if (axi_req.wvalid && st_reg.rsp.wready) begin
         st_next.w_held = 1'b1;
         st_next.wdata  = axi_req.wdata;
         st_next.wstrb  = axi_req.wstrb;
      end
      if (st_reg.rsp.bvalid && axi_req.bready) begin
         st_next.rsp.bvalid = 1'b0;
      end

      do_write = st_reg.aw_held && st_reg.w_held && !st_reg.rsp.bvalid;
      if (do_write) begin
         st_next.aw_held     = 1'b0;
         st_next.w_held      = 1'b0;
         st_next.rsp.bvalid  = 1'b1;
         wr_ok = hit(st_reg.awaddr, cmp_pkg::CTRL_OFS)
              || hit(st_reg.awaddr, cmp_pkg::FLAG_OFS)
              || hit(st_reg.awaddr, cmp_pkg::ENABLE_OFS)
              || hit(st_reg.awaddr, cmp_pkg::PORT_OFS)
              || hit(st_reg.awaddr, cmp_pkg::DIR_OFS);
         st_next.rsp.bresp = wr_ok ? cmp_pkg::RESP_OKAY
                                   : cmp_pkg::RESP_SLVERR;
         if (hit(st_reg.awaddr, cmp_pkg::CTRL_OFS)) begin
            // the write begins with a read of the same register
            ctrl_touch = 1'b1;
         end
         if (st_reg.wstrb[0]) begin
            if (hit(st_reg.awaddr, cmp_pkg::CTRL_OFS)) begin
               st_next.mode = st_reg.wdata[cmp_pkg::MODE_LSB +:
                                           cmp_pkg::MODE_W];
               st_next.inverting_input_select  = st_reg.wdata[cmp_pkg::CIS_BIT];
               st_next.inv  = st_reg.wdata[cmp_pkg::INV_LSB +:
                                           cmp_pkg::NCMP];
            end
            if (hit(st_reg.awaddr, cmp_pkg::FLAG_OFS)) begin
               // a 1 simulates an event; a 0 only clears with no mismatch
               st_next.flag = st_reg.wdata[cmp_pkg::FLAG_LSB +:
                                           cmp_pkg::NCMP]
                            | mismatch;
            end
            if (hit(st_reg.awaddr, cmp_pkg::ENABLE_OFS)) begin
               st_next.ie   = st_reg.wdata[cmp_pkg::IE_LSB +:
                                           cmp_pkg::NCMP];
               st_next.peripheral_interrupt_enable = st_reg.wdata[cmp_pkg::PERIPHERAL_INTERRUPT_ENABLE_BIT];
               st_next.global_interrupt_enable  = st_reg.wdata[cmp_pkg::GIE_BIT];
            end
            if (hit(st_reg.awaddr, cmp_pkg::PORT_OFS)) begin
               st_next.port_latch = st_reg.wdata[cmp_pkg::NPIN-1:0];
            end
            if (hit(st_reg.awaddr, cmp_pkg::DIR_OFS)) begin
               st_next.dir = st_reg.wdata[cmp_pkg::NPIN-1:0];
            end
         end
      end

      // ---- read channel ----
      if (st_reg.rsp.rvalid && axi_req.rready) begin
         st_next.rsp.rvalid = 1'b0;
      end
      do_read = axi_req.arvalid && st_reg.rsp.arready;
      if (do_read) begin
         rd_ok = 1'b1;
         if (hit(axi_req.araddr, cmp_pkg::CTRL_OFS)) begin
            rd = ctrl_word(st_reg, cmp_out);
            ctrl_touch = 1'b1;
         end else if (hit(axi_req.araddr, cmp_pkg::FLAG_OFS)) begin
            rd[cmp_pkg::FLAG_LSB +: cmp_pkg::NCMP] = st_reg.flag;
         end else if (hit(axi_req.araddr, cmp_pkg::ENABLE_OFS)) begin
            rd[cmp_pkg::IE_LSB +: cmp_pkg::NCMP] = st_reg.ie;
            rd[cmp_pkg::PERIPHERAL_INTERRUPT_ENABLE_BIT] = st_reg.peripheral_interrupt_enable;
            rd[cmp_pkg::GIE_BIT]  = st_reg.global_interrupt_enable;
         end else if (hit(axi_req.araddr, cmp_pkg::PORT_OFS)) begin
            rd[cmp_pkg::NPIN-1:0] = pin_in & ~analog_now;
         end else if (hit(axi_req.araddr, cmp_pkg::DIR_OFS)) begin
            rd[cmp_pkg::NPIN-1:0] = st_reg.dir;
         end else begin
            rd_ok = 1'b0;
         end
         st_next.rsp.rvalid = 1'b1;
         st_next.rsp.rdata  = rd;
         st_next.rsp.rresp  = rd_ok ? cmp_pkg::RESP_OKAY
                                    : cmp_pkg::RESP_SLVERR;
      end

      // a change landing in the same cycle as a control access
      // is taken into the reference and so may go unflagged
      if (ctrl_touch) begin
         st_next.ref_latch = cmp_out;
      end

      // ---- ready strobes follow the held slots ----
      st_next.rsp.awready = !st_next.aw_held && !st_next.rsp.bvalid;
      st_next.rsp.wready  = !st_next.w_held && !st_next.rsp.bvalid;
      st_next.rsp.arready = !st_next.rsp.rvalid;

      // ---- interrupt request gating ----
      st_next.irq = |(st_next.flag & st_reg.ie)
                  && st_reg.peripheral_interrupt_enable && st_reg.global_interrupt_enable;

      // ---- analog-side controls follow the mode ----
      m = st_reg.mode;
      st_next.analog = analog_now;
      case (m)
         cmp_pkg::MODE_OFF_ANALOG,
         cmp_pkg::MODE_OFF_DIGITAL: begin
            st_next.enable = 2'h0;
         end
         cmp_pkg::MODE_ONE_CMP: begin
            st_next.enable = 2'h2;
         end
         default: begin
            st_next.enable = 2'h3;
         end
      endcase
      case (m)
         cmp_pkg::MODE_THREE_MUX: begin
            st_next.sel = {1'b0, st_reg.inverting_input_select};
         end
         cmp_pkg::MODE_FOUR_MUX: begin
            st_next.sel = {st_reg.inverting_input_select, st_reg.inverting_input_select};
         end
         default: begin
            st_next.sel = 2'h0;
         end
      endcase

      // ---- pins: ports unless the mode claims them ----
      st_next.pin_oe = ~st_reg.dir;
      for (int i = 0; i < cmp_pkg::NPIN; i++) begin
         st_next.pin_out[i] = st_reg.port_latch[i];
      end
      if (m == cmp_pkg::MODE_REF_OUTPUTS) begin
         st_next.pin_out[cmp_pkg::PIN_C1_OUT] = cmp_out[0];
         st_next.pin_out[cmp_pkg::PIN_C2_OUT] = cmp_out[1];
      end
   end

   // ==========================================================
   // registers
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_reg            <= '0;
         st_reg.mode       <= cmp_pkg::MODE_OFF_ANALOG;
         st_reg.dir        <= cmp_pkg::DIR_RESET;
         st_reg.port_latch <= cmp_pkg::PORT_RESET;
         st_reg.analog     <= cmp_pkg::analog_mask(
                                 cmp_pkg::MODE_OFF_ANALOG);
         st_reg.phase      <= cmp_pkg::QPHASE_Q1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign axi_rsp          = st_reg.rsp;
   assign cmp_enable       = st_reg.enable;
   assign vin_neg_pos_sel  = st_reg.sel;
   assign pin_out          = st_reg.pin_out;
   assign pin_oe           = st_reg.pin_oe;
   assign input_buffer_off = st_reg.analog;
   assign irq_request      = st_reg.irq;

endmodule : dual_comparator_control

// ### testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic              ref_clk = 1'b0;
   logic              reset = 1'b1;
   cmp_pkg::axi_req_t axi_req = '0;
   cmp_pkg::axi_rsp_t axi_rsp;
   logic [1:0]        cmp_raw, cmp_enable, vin_neg_pos_sel;
   logic [1:0]        vin_diff = 2'b00;
   logic [5:0]        ext_level = 6'h3F;
   logic [5:0]        pin_in, pin_out, pin_oe, input_buffer_off;
   logic              irq_request;
   logic [31:0]       rd;
   int                n_errors = 0;
   int                num_checks = 0;

   dual_comparator_control DUT (.ref_clk, .reset, .axi_req, .axi_rsp,
      .cmp_raw, .cmp_enable, .vin_neg_pos_sel, .pin_in, .pin_out, .pin_oe,
      .input_buffer_off, .irq_request);
   cmp_far_side far_i (.ref_clk, .cmp_enable, .vin_diff, .ext_level,
      .pin_out, .pin_oe, .cmp_raw, .pin_in);

   always #12.5 ref_clk = ~ref_clk;

   // ==========================================================
   // bus and compare helpers
   // ==========================================================
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t: %s got %h want %h", $time, what,
                  got, exp);
      end
   endtask : check

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] er = cmp_pkg::RESP_OKAY);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.bready <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge ref_clk);
         if (aw_p && axi_rsp.awready === 1'b1) begin
            aw_p = 1'b0;
            axi_req.awvalid <= 1'b0;
         end
         if (w_p && axi_rsp.wready === 1'b1) begin
            w_p = 1'b0;
            axi_req.wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (axi_rsp.bvalid !== 1'b1);
      axi_req.bready <= 1'b0;
      check(32'(axi_rsp.bresp), 32'(er), "write response");
      @(posedge ref_clk);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           input logic [1:0] er = cmp_pkg::RESP_OKAY);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      do @(posedge ref_clk); while (axi_rsp.arready !== 1'b1);
      axi_req.arvalid <= 1'b0;
      do @(posedge ref_clk); while (axi_rsp.rvalid !== 1'b1);
      axi_req.rready <= 1'b0;
      d = axi_rsp.rdata;
      check(32'(axi_rsp.rresp), 32'(er), "read response");
      @(posedge ref_clk);
   endtask : axi_read

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e, input string what);
      logic [31:0] d;
      axi_read(a, d);
      check(d & m, e, what);
   endtask : rd_chk

   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic test_reset;
      rd_chk(cmp_pkg::CTRL_OFS, 32'h0000_003F, 32'h0, "reset ctrl");
      rd_chk(cmp_pkg::DIR_OFS, 32'h0000_00FF, 32'h3F, "reset dir");
      rd_chk(cmp_pkg::ENABLE_OFS, 32'h0000_00FF, 32'h0, "reset ena");
      axi_write(8'h14, 32'h0, cmp_pkg::RESP_SLVERR);
      axi_read(8'h14, rd, cmp_pkg::RESP_SLVERR);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_modes;
      logic [5:0] am [8] = '{6'h0F, 6'h0F, 6'h0F, 6'h0D, 6'h0F, 6'h0C,
                             6'h0D, 6'h00};
      logic [1:0] en, sel;
      for (int m = 0; m < 8; m++) begin
         axi_write(cmp_pkg::CTRL_OFS, 32'(m) | 32'h0000_0008);
         rd_chk(cmp_pkg::CTRL_OFS, 32'h3F, 32'(m) | 32'h8, "mode");
         rd_chk(cmp_pkg::PORT_OFS, 32'h3F, 32'(am[m] ^ 6'h3F), "port");
         check(32'(input_buffer_off), 32'(am[m]), "analog");
         en = (m == 0 || m == 7) ? 2'b00 : (m == 5) ? 2'b10 : 2'b11;
         check(32'(cmp_enable), 32'(en), "core enable");
         sel = (m == 1) ? 2'b01 : (m == 2) ? 2'b11 : 2'b00;
         check(32'(vin_neg_pos_sel), 32'(sel), "switch");
      end
      axi_write(cmp_pkg::CTRL_OFS, 32'h0000_0002);
      check(32'(vin_neg_pos_sel), 32'h0, "switch low");
      check(32'(input_buffer_off), 32'h0F, "switch analog");
      $display("test_modes done");
   endtask : test_modes

   task automatic test_polarity;
      vin_diff <= 2'b01;
      for (int i = 0; i < 4; i++) begin
         axi_write(cmp_pkg::CTRL_OFS, 32'h0000_0004 | 32'(i << 4));
         repeat (6) @(posedge ref_clk);
         rd_chk(cmp_pkg::CTRL_OFS, 32'hC0,
                32'({2'(i) ^ 2'b01, 6'h00}), "status");
      end
      $display("test_polarity done");
   endtask : test_polarity

   task automatic test_out_pins;
      axi_write(cmp_pkg::DIR_OFS, 32'h0000_000F);
      axi_write(cmp_pkg::PORT_OFS, 32'h0000_002A);
      axi_write(cmp_pkg::CTRL_OFS, 32'h0000_0026);
      vin_diff <= 2'b11;
      repeat (6) @(posedge ref_clk);
      check(32'(pin_out), 32'h0000_001A, "mode 6 pins");
      rd_chk(cmp_pkg::PORT_OFS, 32'h30, 32'h10, "digital pins");
      axi_write(cmp_pkg::CTRL_OFS, 32'h0000_0004);
      check(32'(pin_out), 32'h0000_002A, "port drive");
      axi_write(cmp_pkg::DIR_OFS, 32'h0000_003F);
      $display("test_out_pins done");
   endtask : test_out_pins

   task automatic test_change;
      vin_diff <= 2'b00;
      axi_write(cmp_pkg::CTRL_OFS, 32'h0000_0004);
      repeat (8) @(posedge ref_clk);
      axi_read(cmp_pkg::CTRL_OFS, rd);
      axi_write(cmp_pkg::FLAG_OFS, 32'h0);
      rd_chk(cmp_pkg::FLAG_OFS, 32'h3, 32'h0, "flags quiet");
      vin_diff <= 2'b01;
      repeat (8) @(posedge ref_clk);
      rd_chk(cmp_pkg::FLAG_OFS, 32'h3, 32'h1, "one flag");
      axi_write(cmp_pkg::FLAG_OFS, 32'h0);
      rd_chk(cmp_pkg::FLAG_OFS, 32'h3, 32'h1, "held");
      rd_chk(cmp_pkg::CTRL_OFS, 32'hC0, 32'h40, "status");
      axi_write(cmp_pkg::FLAG_OFS, 32'h0);
      rd_chk(cmp_pkg::FLAG_OFS, 32'h3, 32'h0, "cleared");
      vin_diff <= 2'b11;
      repeat (8) @(posedge ref_clk);
      rd_chk(cmp_pkg::FLAG_OFS, 32'h3, 32'h2, "other flag");
      axi_write(cmp_pkg::CTRL_OFS, 32'h0000_0004);
      axi_write(cmp_pkg::FLAG_OFS, 32'h0);
      rd_chk(cmp_pkg::FLAG_OFS, 32'h3, 32'h0, "write ends");
      axi_write(cmp_pkg::FLAG_OFS, 32'h1);
      rd_chk(cmp_pkg::FLAG_OFS, 32'h3, 32'h1, "soft set");
      $display("test_change done");
   endtask : test_change

   task automatic test_irq;
      for (int k = 0; k < 8; k++) begin
         axi_write(cmp_pkg::ENABLE_OFS, 32'({k[2:1], 1'b0, k[0]}));
         repeat (3) @(posedge ref_clk);
         check(32'(irq_request), 32'(k == 7), "request gate");
      end
      axi_write(cmp_pkg::FLAG_OFS, 32'h0);
      repeat (3) @(posedge ref_clk);
      check(32'(irq_request), 32'h0, "request cleared");
      $display("test_irq done");
   endtask : test_irq

   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("CHECK FAILED %0t: watchdog expired", $time);
      give_verdict();
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (3) @(posedge ref_clk);
      test_reset();
      test_modes();
      test_polarity();
      test_out_pins();
      test_change();
      test_irq();
      give_verdict();
   end
endmodule : testbench
